// [rtl/scm_pkg.sv]
// Purpose: Shared constants and types for the system clock and memory cycle timing block.
// Assumes: One 200 MHz clock, synchronous active-high reset.
// Notes: Clock divide encodings, warm-up count and memory cycle lengths live here.
package scm_pkg;
	// Clock divide field encodings.
	localparam logic [1:0] CD_MULT = 2'h0;
	localparam logic [1:0] CD_DIV4 = 2'h1;
	localparam logic [1:0] CD_DIV1 = 2'h2;
	localparam logic [1:0] CD_DIV1024 = 2'h3;
	// Reset values.
	localparam logic [1:0] CD_RESET = CD_DIV1;
	localparam logic FACTOR_RESET = 1'b0;
	localparam logic MULT_EN_RESET = 1'b0;
	localparam logic SWB_RESET = 1'b0;
	// Bit positions in the power management register and the external flag register.
	localparam int PMR_CD_HI_POS = 7;
	localparam int PMR_CD_LO_POS = 6;
	localparam int PMR_SWB_POS = 5;
	localparam int PMR_MULT_EN_POS = 4;
	localparam int EXTERNAL_INTERRUPT_FLAG_REGISTER_READY_POS = 3;
	localparam int EXTERNAL_INTERRUPT_FLAG_REGISTER_RING_POS = 2;
	// Warm-up length in external clock cycles.
	localparam int WARMUP_CYCLES = 65536;
	// Divide-by-1024 prescale count.
	localparam int SLOW_DIV = 1024;
	// Memory cycle lengths in system clocks.
	localparam logic [3:0] MC_INTERNAL = 4'h1;
	localparam logic [3:0] MC_NONPAGE = 4'h4;
	localparam logic [3:0] MC_PAGE4_HIT = 4'h4;
	localparam logic [3:0] MC_PAGE4_MISS = 4'h8;
	localparam logic [3:0] MC_PAGE2_HIT = 4'h2;
	localparam logic [3:0] MC_PAGE2_MISS = 4'h4;
	localparam logic [3:0] MC_PAGE1_HIT = 4'h1;
	localparam logic [3:0] MC_PAGE1_MISS = 4'h2;
	// Page mode select field encodings.
	localparam logic [1:0] PG_ONE = 2'h0;
	localparam logic [1:0] PG_TWO = 2'h1;
	localparam logic [1:0] PG_FOUR = 2'h2;
	localparam logic [1:0] PG_MODE2 = 2'h3;
	// Opcodes with their own cycle counts; some add a cycle for special direct operands.
	localparam logic [7:0] OP_RRC = 8'h13;
	localparam logic [7:0] OP_DAA = 8'hD4;
	localparam logic [7:0] OP_RET = 8'h22;
	localparam logic [7:0] OP_MUL = 8'hA4;
	localparam logic [7:0] OP_DIV = 8'h84;
	localparam logic [7:0] OP_JBC = 8'h10;
	localparam logic [7:0] OP_ADD_DIR = 8'h25;
	localparam logic [7:0] OP_ADD_IMM = 8'h24;
	localparam logic [7:0] OP_SJMP = 8'h80;
	localparam logic [7:0] OP_ANL_DIR = 8'h52;
	localparam logic [7:0] OP_ORL_DIR = 8'h42;
	localparam logic [7:0] OP_LJMP = 8'h02;
	localparam logic [7:0] OP_MOV_DPTR = 8'h90;
	localparam logic [7:0] OP_MOV_DD = 8'h85;
	localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
	localparam logic [4:0] OP_DJNZ_RN_HI = 5'h1B;
	// Special registers whose direct access costs one extra memory cycle.
	localparam logic [7:0] SFR_PSW = 8'hD0;
	localparam logic [7:0] SFR_SP = 8'h81;
	localparam logic [7:0] SFR_DPS = 8'h86;
	localparam logic [7:0] SFR_IE = 8'hA8;
	localparam logic [7:0] SFR_EIE = 8'hE8;
	localparam logic [7:0] SFR_IP0 = 8'hB8;
	localparam logic [7:0] SFR_IP1 = 8'hB1;
	localparam logic [7:0] SFR_EIP0 = 8'hF8;
	localparam logic [7:0] SFR_EXTENDED_PRIORITY_HIGH_REG = 8'hF1;

	// A software write to the clock control bits.
	typedef struct packed {
		logic [1:0] clock_divide_field;
		logic multiply_factor_select;
		logic multiplier_enable;
		logic switchback_enable;
	} scm_ctrl_t;

	// Timing of one decoded instruction.
	typedef struct packed {
		logic [1:0] bytes;
		logic [3:0] cycles;
	} scm_itime_t;
endpackage

// [rtl/scm_instr_timing.sv]
// Purpose: Decodes an opcode into byte count and memory cycle count.
// Assumes: Operand address and branch outcome are given by the core.
// Notes: Opcodes not listed take one byte and one cycle.
module scm_instr_timing (
	input wire logic [7:0] opcode,
	input wire logic [7:0] direct_addr,
	input wire logic branch_taken,
	output scm_pkg::scm_itime_t itime
);
	logic special;

	// Flags direct targets that cost one extra cycle.
	always_comb begin
		special = (direct_addr == scm_pkg::SFR_PSW) || (direct_addr == scm_pkg::SFR_SP) ||
			(direct_addr == scm_pkg::SFR_DPS) || (direct_addr == scm_pkg::SFR_IE) ||
			(direct_addr == scm_pkg::SFR_EIE) || (direct_addr == scm_pkg::SFR_IP0) ||
			(direct_addr == scm_pkg::SFR_IP1) || (direct_addr == scm_pkg::SFR_EIP0) ||
			(direct_addr == scm_pkg::SFR_EXTENDED_PRIORITY_HIGH_REG);
	end

	// Byte and cycle counts per opcode.
	always_comb begin
		itime.bytes = 2'h1;
		itime.cycles = 4'h1;
		if (opcode[7:3] == scm_pkg::OP_DJNZ_RN_HI) begin
			itime.bytes = 2'h2;
			itime.cycles = 4'h4;
		end else begin
			unique case (opcode)
				scm_pkg::OP_RRC: itime.cycles = 4'h1;
				scm_pkg::OP_DAA: itime.cycles = 4'h2;
				scm_pkg::OP_RET: itime.cycles = 4'h3;
				scm_pkg::OP_MUL: itime.cycles = 4'h9;
				scm_pkg::OP_DIV: itime.cycles = 4'hA;
				scm_pkg::OP_ADD_DIR, scm_pkg::OP_ADD_IMM: begin
					itime.bytes = 2'h2;
					itime.cycles = 4'h2;
				end
				scm_pkg::OP_SJMP: begin
					itime.bytes = 2'h2;
					itime.cycles = 4'h3;
				end
				scm_pkg::OP_ANL_DIR, scm_pkg::OP_ORL_DIR: begin
					itime.bytes = 2'h2;
					itime.cycles = special ? 4'h3 : 4'h2;
				end
				scm_pkg::OP_LJMP, scm_pkg::OP_MOV_DPTR: begin
					itime.bytes = 2'h3;
					itime.cycles = 4'h3;
				end
				scm_pkg::OP_MOV_DD: begin
					itime.bytes = 2'h3;
					itime.cycles = special ? 4'h4 : 4'h3;
				end
				scm_pkg::OP_JBC: begin
					itime.bytes = 2'h3;
					itime.cycles = (branch_taken && special) ? 4'h5 : 4'h4;
				end
				scm_pkg::OP_DJNZ_DIR: begin
					itime.bytes = 2'h3;
					itime.cycles = 4'h5;
				end
				default: itime.cycles = 4'h1;
			endcase
		end
	end
endmodule

// [rtl/scm_warmup.sv]
// Purpose: Counts the crystal multiplier warm-up and raises ready.
// Assumes: Counted on the block clock, which stands for the external clock.
// Notes: Clearing the enable restarts the warm-up.
module scm_warmup #(
	parameter int WARMUP = scm_pkg::WARMUP_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	output logic ready
);
	logic [16:0] count_r;

	// Counts while enabled and holds ready low until the count ends.
	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			count_r <= 17'h00000;
			ready <= 1'b0;
		end else if (count_r == 17'(WARMUP - 1)) begin
			ready <= 1'b1;
		end else begin
			count_r <= count_r + 17'h00001;
		end
	end
endmodule

// [rtl/scm_top.sv]
// Purpose: System clock divide control and memory cycle timing.
// Assumes: Core fetch requests are same-clock; wake events come from pins.
// Notes: The system clock is produced as a one-cycle enable tick.
// Function
// - System clock derived at ratio 0.25, 0.5, 1 or 1024 by divide field; sys_tick fires every clock except for 11b, which ticks every 1024.
// - Field 10b is divide-by-1; 00b selects the multiplier output.
// - Factor bit changes only in divide-by-1 with multiplier disabled.
// - Setting multiplier enable starts warm-up in the selected factor.
// - Multiplier enable changes only in divide-by-1 with ring mode clear.
// - During warm-up ready stays 0 and writes of 00b are refused.
// - Warm-up end sets ready; then 00b may be selected.
// - Warm-up lasts about 65536 external clock cycles.
// - After writing 00b the multiplier clock starts at the next memory cycle.
// - Switchback returns divide-by-1024 to divide-by-1 on interrupt or start bit.
// - Switchback acts only in divide-by-1024; otherwise field unchanged.
// - Internal program memory cycles are one system clock long.
// - External memory cycles are 1, 2, 4 or 8 system clocks by bus mode.
// - External interface starts in nonpage mode with four-clock cycles.
// - Nonpage mode pulses the address latch strobe on every fetch.
// - Extra execution cycles stall the program counter with dummy fetches.
// - A fetch into a new 256-byte page drives the new high byte on port 2.
// - Instructions take one to ten memory cycles as per opcode.
// - Direct ANL, ORL, MOV and taken JBC on listed special registers take one extra cycle.
// - Each instruction byte fetch uses one memory cycle.
// - Page modes set by field first, then enable; 10b gives 4 and 8 clocks.
module scm_top #(
	parameter int WARMUP = scm_pkg::WARMUP_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctrl_wr,
	input scm_pkg::scm_ctrl_t ctrl_wdata,
	input wire logic page_wr,
	input wire logic [1:0] page_sel_wdata,
	input wire logic page_en_wdata,
	input wire logic ring_oscillator_mode_status,
	input wire logic ext_int_pin,
	input wire logic serial_start_pin,
	input wire logic fetch_external,
	input wire logic [15:0] fetch_addr,
	input wire logic [7:0] opcode,
	input wire logic [7:0] direct_addr,
	input wire logic branch_taken,
	input wire logic instr_start,
	output logic [1:0] clock_divide_field,
	output logic multiply_factor_select,
	output logic multiplier_enable,
	output logic switchback_enable,
	output logic clock_ready_flag,
	output logic sys_tick,
	output logic mem_cycle_end,
	output logic pc_stall,
	output logic dummy_fetch,
	output logic addr_latch_strobe,
	output logic [7:0] port2_addr_hi,
	output logic [7:0] port0_addr_lo
);
	logic [1:0] cd_r;
	logic [1:0] cd_active_r;
	logic factor_r;
	logic mult_en_r;
	logic swb_r;
	logic ring_s1_r;
	logic ring_s2_r;
	logic int_s1_r;
	logic int_s2_r;
	logic ser_s1_r;
	logic ser_s2_r;
	logic ready;
	logic [9:0] slow_cnt_r;
	logic tick_nxt;
	logic [1:0] page_sel_r;
	logic page_en_r;
	logic [3:0] clk_in_mc_r;
	logic [3:0] mc_len;
	logic mc_done;
	logic page_miss;
	logic [7:0] last_page_r;
	logic [3:0] exec_left_r;
	logic [1:0] bytes_left_r;
	logic wake;
	scm_pkg::scm_itime_t itime;

	scm_warmup #(
		.WARMUP(WARMUP)
	) u_warmup (
		.clk(clk),
		.rst(rst),
		.enable(mult_en_r),
		.ready(ready)
	);

	scm_instr_timing u_timing (
		.opcode(opcode),
		.direct_addr(direct_addr),
		.branch_taken(branch_taken),
		.itime(itime)
	);

	// Synchronises the ring status and wake pins.
	always_ff @(posedge clk) begin
		if (rst) begin
			ring_s1_r <= 1'b0;
			ring_s2_r <= 1'b0;
			int_s1_r <= 1'b0;
			int_s2_r <= 1'b0;
			ser_s1_r <= 1'b0;
			ser_s2_r <= 1'b0;
		end else begin
			ring_s1_r <= ring_oscillator_mode_status;
			ring_s2_r <= ring_s1_r;
			int_s1_r <= ext_int_pin;
			int_s2_r <= int_s1_r;
			ser_s1_r <= serial_start_pin;
			ser_s2_r <= ser_s1_r;
		end
	end

	assign wake = int_s2_r || ser_s2_r;

	// Multiplier factor and enable, each guarded by its own conditions.
	always_ff @(posedge clk) begin
		if (rst) begin
			factor_r <= scm_pkg::FACTOR_RESET;
			mult_en_r <= scm_pkg::MULT_EN_RESET;
			swb_r <= scm_pkg::SWB_RESET;
		end else if (ctrl_wr) begin
			swb_r <= ctrl_wdata.switchback_enable;
			if (cd_r == scm_pkg::CD_DIV1 && !mult_en_r) begin
				factor_r <= ctrl_wdata.multiply_factor_select;
			end
			if (cd_r == scm_pkg::CD_DIV1 && !ring_s2_r) begin
				mult_en_r <= ctrl_wdata.multiplier_enable;
			end
		end
	end

	// Clock divide field: software writes, refusal during warm-up, switchback.
	always_ff @(posedge clk) begin
		if (rst) begin
			cd_r <= scm_pkg::CD_RESET;
		end else if (swb_r && cd_r == scm_pkg::CD_DIV1024 && wake) begin
			cd_r <= scm_pkg::CD_DIV1;
		end else if (ctrl_wr) begin
			if (ctrl_wdata.clock_divide_field != scm_pkg::CD_MULT) begin
				cd_r <= ctrl_wdata.clock_divide_field;
			end else if (mult_en_r && ready) begin
				cd_r <= scm_pkg::CD_MULT;
			end
		end
	end

	// The active source follows the field at once, except that 00b waits for a memory cycle boundary.
	always_ff @(posedge clk) begin
		if (rst) begin
			cd_active_r <= scm_pkg::CD_RESET;
		end else if (mc_done || cd_r != scm_pkg::CD_MULT) begin
			cd_active_r <= cd_r;
		end
	end

	// System clock tick: multiplier modes tick every clock, slow mode every 1024.
	always_comb begin
		unique case (cd_active_r)
			scm_pkg::CD_MULT: tick_nxt = 1'b1;
			scm_pkg::CD_DIV1024: tick_nxt = (slow_cnt_r == 10'(scm_pkg::SLOW_DIV - 1));
			default: tick_nxt = 1'b1;
		endcase
	end

	// Prescaler counter for the divide-by-1024 source.
	always_ff @(posedge clk) begin
		if (rst || cd_active_r != scm_pkg::CD_DIV1024) begin
			slow_cnt_r <= 10'h000;
		end else begin
			slow_cnt_r <= slow_cnt_r + 10'h001;
		end
	end

	// Page mode field is written first, enable afterwards.
	always_ff @(posedge clk) begin
		if (rst) begin
			page_sel_r <= scm_pkg::PG_FOUR;
			page_en_r <= 1'b0;
		end else if (page_wr) begin
			if (!page_en_wdata) begin
				page_sel_r <= page_sel_wdata;
				page_en_r <= 1'b0;
			end else begin
				page_en_r <= 1'b1;
			end
		end
	end

	assign page_miss = fetch_addr[15:8] != last_page_r;

	// Memory cycle length in system clocks for the current mode.
	always_comb begin
		if (!fetch_external) begin
			mc_len = scm_pkg::MC_INTERNAL;
		end else if (!page_en_r) begin
			mc_len = scm_pkg::MC_NONPAGE;
		end else begin
			unique case (page_sel_r)
				scm_pkg::PG_FOUR: mc_len = page_miss ? scm_pkg::MC_PAGE4_MISS
					: scm_pkg::MC_PAGE4_HIT;
				scm_pkg::PG_TWO: mc_len = page_miss ? scm_pkg::MC_PAGE2_MISS
					: scm_pkg::MC_PAGE2_HIT;
				scm_pkg::PG_ONE: mc_len = page_miss ? scm_pkg::MC_PAGE1_MISS
					: scm_pkg::MC_PAGE1_HIT;
				scm_pkg::PG_MODE2: mc_len = page_miss ? scm_pkg::MC_PAGE2_MISS
					: scm_pkg::MC_PAGE2_HIT;
			endcase
		end
	end

	// A shorter length chosen mid-cycle ends the cycle at once instead of wrapping the count.
	assign mc_done = tick_nxt && (clk_in_mc_r >= mc_len - 4'h1);

	// Counts system clocks within one memory cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_in_mc_r <= 4'h0;
		end else if (mc_done) begin
			clk_in_mc_r <= 4'h0;
		end else if (tick_nxt) begin
			clk_in_mc_r <= clk_in_mc_r + 4'h1;
		end
	end

	// Tracks remaining bytes and execution cycles of the current instruction.
	always_ff @(posedge clk) begin
		if (rst) begin
			exec_left_r <= 4'h0;
			bytes_left_r <= 2'h0;
		end else if (mc_done) begin
			if (instr_start && exec_left_r <= 4'h1) begin
				exec_left_r <= itime.cycles - 4'h1;
				bytes_left_r <= itime.bytes - 2'h1;
			end else if (exec_left_r != 4'h0) begin
				exec_left_r <= exec_left_r - 4'h1;
				if (bytes_left_r != 2'h0) begin
					bytes_left_r <= bytes_left_r - 2'h1;
				end
			end
		end
	end

	// Stall and dummy fetch when execution outruns the instruction bytes.
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_stall <= 1'b0;
			dummy_fetch <= 1'b0;
		end else begin
			pc_stall <= exec_left_r != 4'h0 && bytes_left_r == 2'h0;
			dummy_fetch <= mc_done && exec_left_r != 4'h0 && bytes_left_r == 2'h0;
		end
	end

	// Address outputs, and latch strobe at the start of each nonpage or page-miss memory cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_latch_strobe <= 1'b0;
			port2_addr_hi <= 8'h00;
			port0_addr_lo <= 8'h00;
			last_page_r <= 8'h00;
		end else begin
			addr_latch_strobe <= fetch_external && tick_nxt && clk_in_mc_r == 4'h0
				&& (!page_en_r || page_miss);
			if (fetch_external && page_miss) begin
				port2_addr_hi <= fetch_addr[15:8];
			end
			// The page is recorded at cycle end so a miss cycle keeps its long length.
			if (fetch_external && page_miss && mc_done) begin
				last_page_r <= fetch_addr[15:8];
			end
			port0_addr_lo <= fetch_addr[7:0];
		end
	end

	// Registered copies of control state and timing strobes.
	always_ff @(posedge clk) begin
		if (rst) begin
			clock_divide_field <= scm_pkg::CD_RESET;
			multiply_factor_select <= scm_pkg::FACTOR_RESET;
			multiplier_enable <= scm_pkg::MULT_EN_RESET;
			switchback_enable <= scm_pkg::SWB_RESET;
			clock_ready_flag <= 1'b0;
			sys_tick <= 1'b0;
			mem_cycle_end <= 1'b0;
		end else begin
			clock_divide_field <= cd_r;
			multiply_factor_select <= factor_r;
			multiplier_enable <= mult_en_r;
			switchback_enable <= swb_r;
			clock_ready_flag <= ready;
			sys_tick <= tick_nxt;
			mem_cycle_end <= mc_done;
		end
	end
endmodule

// [verification/scm_top_assertions.sv]
// Purpose: Concurrent checks on the clock control and memory cycle ports.
// Assumes: Outputs lag the internal state by one clock; WARMUP may be shortened.
// Notes: Small counters measure pulse gaps and how long a mode has been held.
module scm_top_checker #(
	parameter int WARMUP = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctrl_wr,
	input wire logic page_wr,
	input wire logic page_en_wdata,
	input wire logic ext_int_pin,
	input wire logic serial_start_pin,
	input wire logic fetch_external,
	input wire logic [1:0] clock_divide_field,
	input wire logic multiply_factor_select,
	input wire logic multiplier_enable,
	input wire logic switchback_enable,
	input wire logic clock_ready_flag,
	input wire logic sys_tick,
	input wire logic mem_cycle_end,
	input wire logic addr_latch_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	int hold, gap, tgap, slow, en_cnt;
	logic ale_seen, prev_ext, pg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Counters restart on reset so stale gaps never reach an assertion.
	always_ff @(posedge clk) begin
		if (rst) begin
			hold <= 0;
			gap <= 0;
			tgap <= 0;
			slow <= 0;
			en_cnt <= 0;
			ale_seen <= 1'b0;
			pg <= 1'b0;
		end else begin
			pg <= page_wr ? page_en_wdata : pg;
			hold <= (clock_divide_field != 2'h2 || prev_ext != fetch_external
				|| page_wr) ? 0 : hold + 1;
			gap <= mem_cycle_end ? 0 : gap + 1;
			tgap <= sys_tick ? 0 : tgap + 1;
			slow <= (clock_divide_field == 2'h3) ? slow + 1 : 0;
			en_cnt <= multiplier_enable ? en_cnt + 1 : 0;
			ale_seen <= addr_latch_strobe || (ale_seen && !mem_cycle_end);
		end
		prev_ext <= fetch_external;
	end
	a_reset_div_one: assert property ($fell(rst) |-> clock_divide_field == 2'h2 && !multiplier_enable && !clock_ready_flag) else $error("reset values wrong");
	a_factor_locked: assert property ($changed(multiply_factor_select) |-> $past(clock_divide_field) == 2'h2 && !$past(multiplier_enable)) else $error("factor changed while locked");
	a_enable_locked: assert property ($changed(multiplier_enable) |-> $past(clock_divide_field) == 2'h2) else $error("enable changed outside divide-by-1");
	a_ready_drops: assert property (!multiplier_enable [*3] |-> !clock_ready_flag) else $error("ready without enable");
	a_warmup_len: assert property ($rose(clock_ready_flag) |-> en_cnt >= WARMUP - 1 && en_cnt <= WARMUP + 2) else $error("warm-up length wrong");
	a_mult_ready: assert property ($changed(clock_divide_field) && clock_divide_field == 2'h0 |-> clock_ready_flag) else $error("multiplier chosen before ready");
	a_field_cause: assert property ($changed(clock_divide_field) |-> $past(ctrl_wr, 2) || ($past(clock_divide_field) == 2'h3 && switchback_enable)) else $error("field changed without cause");
	a_switch_back: assert property (clock_divide_field == 2'h3 && switchback_enable && (ext_int_pin || serial_start_pin) |-> ##[1:8] clock_divide_field == 2'h2) else $error("no switchback");
	a_mem_cycle_len: assert property (mem_cycle_end && hold > 12 |-> gap == (fetch_external ? 3 : 0)) else $error("memory cycle length wrong");
	a_slow_tick: assert property (sys_tick && slow > 2100 |-> tgap == 1023) else $error("slow tick spacing wrong");
	a_strobe_each: assert property (mem_cycle_end && hold > 12 && fetch_external && !pg |-> ale_seen || addr_latch_strobe) else $error("no address strobe in cycle");
	c_ready: cover property ($rose(clock_ready_flag));
	c_mult: cover property (clock_divide_field == 2'h0);
	c_back: cover property ($past(clock_divide_field) == 2'h3 && clock_divide_field == 2'h2);
endmodule

bind scm_top scm_top_checker #(.WARMUP(WARMUP)) u_checker (.clk(clk), .rst(rst),
	.ctrl_wr(ctrl_wr), .page_wr(page_wr), .page_en_wdata(page_en_wdata),
	.ext_int_pin(ext_int_pin), .serial_start_pin(serial_start_pin),
	.fetch_external(fetch_external), .clock_divide_field(clock_divide_field),
	.multiply_factor_select(multiply_factor_select), .multiplier_enable(multiplier_enable),
	.switchback_enable(switchback_enable), .clock_ready_flag(clock_ready_flag),
	.sys_tick(sys_tick), .mem_cycle_end(mem_cycle_end), .addr_latch_strobe(addr_latch_strobe));

// [verification/scm_prog_mem.sv]
// Purpose: External program memory beside the multiplexed address ports.
// Assumes: The full address is present while the latch strobe is high.
// Notes: Counts fetches so the bench can judge strobe activity.
module scm_prog_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic addr_latch_strobe,
	input wire logic [7:0] port2_addr_hi,
	input wire logic [7:0] port0_addr_lo,
	output logic [15:0] latched_addr,
	output int n_fetch
);
	timeunit 1ns;
	timeprecision 100ps;
	// Capture the fetch address on each strobe, as an external latch would.
	always_ff @(posedge clk) begin
		if (rst) begin
			latched_addr <= 16'h0000;
			n_fetch <= 0;
		end else if (addr_latch_strobe) begin
			latched_addr <= {port2_addr_hi, port0_addr_lo};
			n_fetch <= n_fetch + 1;
		end
	end
endmodule

// [verification/tb_sysclk_divide_and_memcycle_timing.sv]
// Purpose: Self-checking bench for the clock control and memory cycle block.
// Assumes: 200 MHz clock; inputs change 1 ns after the rising edge.
// Notes: WARMUP is shortened to 16 so the warm-up ends quickly.
module tb_sysclk_divide_and_memcycle_timing;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WARMUP = 16;
	logic clk, rst, ctrl_wr, page_wr, page_en_wdata, ring, ext_int_pin, serial_start_pin;
	logic fetch_external, branch_taken, instr_start, e_f, e_en, e_sw, e_rdy, rf;
	logic [1:0] page_sel_wdata, e_cd, clock_divide_field;
	logic [15:0] fetch_addr, lat_addr;
	logic [7:0] opcode, direct_addr, port2_addr_hi, port0_addr_lo;
	logic multiply_factor_select, multiplier_enable, switchback_enable, clock_ready_flag;
	logic sys_tick, mem_cycle_end, pc_stall, dummy_fetch, addr_latch_strobe;
	scm_pkg::scm_ctrl_t ctrl_wdata;
	int n_mismatch, n_tests, n_fetch, cnt, ce, tk, df, nf, ps;
	logic [7:0] ops [15] = '{8'h13, 8'hD4, 8'h22, 8'hA4, 8'h84, 8'h25, 8'h24, 8'h80,
		8'h52, 8'h42, 8'h02, 8'h90, 8'h85, 8'h10, 8'hD5};
	scm_top #(.WARMUP(WARMUP)) dut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .page_wr(page_wr), .page_sel_wdata(page_sel_wdata),
		.page_en_wdata(page_en_wdata), .ring_oscillator_mode_status(ring),
		.ext_int_pin(ext_int_pin), .serial_start_pin(serial_start_pin),
		.fetch_external(fetch_external), .fetch_addr(fetch_addr), .opcode(opcode),
		.direct_addr(direct_addr), .branch_taken(branch_taken), .instr_start(instr_start),
		.clock_divide_field(clock_divide_field), .multiply_factor_select(multiply_factor_select),
		.multiplier_enable(multiplier_enable), .switchback_enable(switchback_enable),
		.clock_ready_flag(clock_ready_flag), .sys_tick(sys_tick), .mem_cycle_end(mem_cycle_end),
		.pc_stall(pc_stall), .dummy_fetch(dummy_fetch), .addr_latch_strobe(addr_latch_strobe),
		.port2_addr_hi(port2_addr_hi), .port0_addr_lo(port0_addr_lo));
	scm_prog_mem mem (.clk(clk), .rst(rst), .addr_latch_strobe(addr_latch_strobe),
		.port2_addr_hi(port2_addr_hi), .port0_addr_lo(port0_addr_lo),
		.latched_addr(lat_addr), .n_fetch(n_fetch));
	// Free-running 5 ns clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Direct operands that cost one extra memory cycle.
	function automatic int sfr(logic [7:0] da);
		return int'(da inside {scm_pkg::SFR_PSW, scm_pkg::SFR_SP, scm_pkg::SFR_DPS,
			scm_pkg::SFR_IE, scm_pkg::SFR_EIE, scm_pkg::SFR_IP0, scm_pkg::SFR_IP1,
			scm_pkg::SFR_EIP0, scm_pkg::SFR_EXTENDED_PRIORITY_HIGH_REG});
	endfunction
	// Memory cycles an instruction needs.
	function automatic int exp_cyc(logic [7:0] op, logic [7:0] da, logic bt);
		case (op)
			8'h13: return 1;
			8'hD4, 8'h25, 8'h24: return 2;
			8'h22, 8'h80, 8'h02, 8'h90: return 3;
			8'hA4: return 9;
			8'h84: return 10;
			8'h52, 8'h42: return 2 + sfr(da);
			8'h85: return 3 + sfr(da);
			8'h10: return 4 + (bt ? sfr(da) : 0);
			8'hD5: return 5;
			default: return (op[7:3] == 5'h1B) ? 4 : 1;
		endcase
	endfunction
	// Bytes an instruction occupies.
	function automatic int exp_bytes(logic [7:0] op);
		if (op inside {8'h02, 8'h90, 8'h85, 8'h10, 8'hD5}) return 3;
		if (op inside {8'h25, 8'h24, 8'h80, 8'h52, 8'h42} || op[7:3] == 5'h1B) return 2;
		return 1;
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One control write; the expected bits follow the acceptance conditions.
	task automatic wr(logic [1:0] cd, logic f, logic en, logic sw);
		logic [1:0] ncd;
		ncd = (cd != 2'h0 || (e_en && e_rdy)) ? cd : e_cd;
		if (e_cd == 2'h2 && !e_en) e_f = f;
		if (e_cd == 2'h2 && !ring) begin
			e_rdy = e_rdy & en & e_en;
			e_en = en;
		end
		e_cd = ncd;
		e_sw = sw;
		ctrl_wdata = {cd, f, en, sw};
		ctrl_wr = 1'b1;
		step(1);
		ctrl_wr = 1'b0;
		step(3);
		check("field", 16'(clock_divide_field), 16'(e_cd));
		check("factor", 16'(multiply_factor_select), 16'(e_f));
		check("enable", 16'(multiplier_enable), 16'(e_en));
		check("switchback", 16'(switchback_enable), 16'(e_sw));
	endtask
	task automatic count(int n);
		ce = 0;
		tk = 0;
		df = 0;
		ps = 0;
		repeat (n) begin
			step(1);
			ps += int'(pc_stall === 1'b1);
			ce += int'(mem_cycle_end === 1'b1);
			tk += int'(sys_tick === 1'b1);
			df += int'(dummy_fetch === 1'b1);
		end
	endtask
	task automatic wake(int which);
		ext_int_pin = (which == 0);
		serial_start_pin = (which == 1);
		step(4);
		ext_int_pin = 1'b0;
		serial_start_pin = 1'b0;
		step(8);
		check("field", 16'(clock_divide_field), 16'(e_cd));
	endtask
	// Main sequence: reset, refusals, warm-up, switchback, memory cycles, instructions.
	initial begin
		{ctrl_wr, page_wr, page_en_wdata, ring, ext_int_pin, serial_start_pin} = 6'h00;
		{fetch_external, branch_taken, instr_start} = 3'h0;
		page_sel_wdata = 2'h2;
		ctrl_wdata = 5'h10;
		fetch_addr = 16'h0000;
		opcode = 8'h00;
		direct_addr = 8'h00;
		rst = 1'b1;
		void'($urandom(92));
		step(8);
		rst = 1'b0;
		step(2);
		{e_cd, e_f, e_en, e_sw, e_rdy} = 6'h20;
		check("reset field", 16'(clock_divide_field), 16'h0002);
		check("reset ready", 16'(clock_ready_flag), 16'h0000);
		wr(2'h0, 1'b0, 1'b0, 1'b0);
		ring = 1'b1;
		step(4);
		wr(2'h2, 1'b0, 1'b1, 1'b0);
		ring = 1'b0;
		step(4);
		rf = 1'($urandom);
		wr(2'h2, 1'b0, 1'b0, 1'b0);
		wr(2'h2, rf, 1'b0, 1'b0);
		wr(2'h2, rf, 1'b1, 1'b0);
		wr(2'h0, rf, 1'b1, 1'b0);
		wr(2'h2, !rf, 1'b1, 1'b0);
		check("ready early", 16'(clock_ready_flag), 16'h0000);
		cnt = 0;
		while (clock_ready_flag !== 1'b1 && cnt < WARMUP + 40) begin
			step(1);
			cnt++;
		end
		if (clock_ready_flag !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		check("warm-up length", 16'(cnt + 11), 16'(WARMUP + 1));
		e_rdy = 1'b1;
		wr(2'h0, rf, 1'b1, 1'b0);
		wr(2'h0, rf, 1'b0, 1'b0);
		wr(2'h2, rf, 1'b1, 1'b0);
		wr(2'h2, rf, 1'b0, 1'b0);
		step(4);
		check("ready cleared", 16'(clock_ready_flag), 16'h0000);
		for (int i = 0; i < 2; i++) begin
			wr(2'h3, e_f, 1'b0, 1'b1);
			count(4096);
			check("slow ticks", 16'(tk), 16'h0004);
			e_cd = 2'h2;
			wake(i);
			wake(1 - i);
			wr(2'h3, e_f, 1'b0, 1'b0);
			wake(i);
		end
		wr(2'h2, e_f, 1'b0, 1'b0);
		fetch_addr = 16'($urandom);
		fetch_external = 1'b1;
		for (int p = 0; p < 2; p++) begin
			step(20);
			nf = n_fetch;
			count(400);
			check("ext cycles", 16'(ce), 16'h0064);
			check("fetches", 16'(n_fetch - nf), 16'h0064);
			check("port2", 16'(port2_addr_hi), 16'(fetch_addr[15:8]));
			check("latched high", 16'(lat_addr[15:8]), 16'(fetch_addr[15:8]));
			check("latched low", 16'(lat_addr[7:0]), 16'(fetch_addr[7:0]));
			fetch_addr = fetch_addr + 16'h0100;
		end
		// Four-clock page mode: field first, then enable; same-page fetches need no strobe.
		page_wr = 1'b1;
		step(1);
		page_en_wdata = 1'b1;
		step(1);
		page_wr = 1'b0;
		step(20);
		nf = n_fetch;
		count(400);
		check("page hits", 16'(ce), 16'h0064);
		check("page fetches", 16'(n_fetch - nf), 16'h0000);
		fetch_external = 1'b0;
		step(20);
		count(400);
		check("int cycles", 16'(ce), 16'h0190);
		for (int k = 0; k < 31; k++) begin
			opcode = (k == 30) ? {5'h1B, 3'($urandom)} : ops[k % 15];
			direct_addr = (k < 15) ? 8'h90 : scm_pkg::SFR_IE;
			branch_taken = (k >= 15);
			instr_start = 1'b1;
			step(1);
			instr_start = 1'b0;
			count(16);
			cnt = exp_cyc(opcode, direct_addr, branch_taken) - exp_bytes(opcode);
			check("dummies", 16'(df), 16'(cnt));
			check("stalls", 16'(ps), 16'(cnt));
		end
		summarize();
	end
endmodule
